// >>> src/bpps_sequencer.sv
// PROM read and fuse-program sequencer with AXI4-Lite register access.
// What this block does
// - Pulse nibble bits one at a time, repeating.
// - Read back each bit before pulsing it.
// - After all blown, count 128 matching read-backs.
// - Then drive all cleared outputs 2.5 ms.
// - Wide parts: lower nibble before upper nibble.
// - Supply pulse with current on one bit.
// - Board requests; device answers with data, status.
// - Return addressed word on 8-bit read bus.
// - Only addresses 0 to 2047; top bit errors.
// - Size switch picks bits 8-10 checked.
// - Out-of-range address raises boundary error flag.
// - Missing high voltage shows a status bit.
// - Count 128 matches, then start over-programming.
// - Four 400 ms attempts, then abort with error.
// - Check range before each operation, supply before programming.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module bpps_sequencer
  import bpps_pkg::*;
#(
  parameter int CYCLE_LIMIT = bpps_pkg::CYCLE_CYCLES,
  parameter int OVP_LIMIT = bpps_pkg::OVP_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [bpps_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [bpps_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [10:0] promAddr,
  output logic promSelectN,
  input wire logic [bpps_pkg::PROM_DATA_W-1:0] promData,
  output logic supplyPulse,
  output logic [bpps_pkg::PROM_DATA_W-1:0] currentDrive,
  input wire logic hvMissing,
  input wire logic [1:0] sizeSelectSwitch,
  output logic irq
);
  import bpps_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] pickNibble(input logic [7:0] word, input logic upper);
    pickNibble = upper ? word[7:4] : word[3:0];
  endfunction

  function automatic logic [7:0] driveVector(input logic upper, input logic [3:0] bits);
    driveVector = upper ? {bits, 4'h0} : {4'h0, bits};
  endfunction

  function automatic logic rangeError(input logic [11:0] addr, input logic [1:0] size);
    logic [2:0] checkMask;
    checkMask = (size == 2'h0) ? 3'h7 : (size == 2'h1) ? 3'h6 : (size == 2'h2) ? 3'h4 : 3'h0;
    rangeError = addr[11] || ((addr[10:8] & checkMask) != 3'h0);
  endfunction

  // ----------------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] syncLevel;
  logic [7:0] dataSync;
  logic supplyMissing;
  logic [1:0] sizeSync;

  bpps_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .pinIn({sizeSelectSwitch, hvMissing, promData}),
    .level(syncLevel)
  );
  assign dataSync = syncLevel[7:0];
  assign supplyMissing = syncLevel[8];
  assign sizeSync = syncLevel[10:9];

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  bpps_state_t state_reg, state_next;
  logic awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
  logic [4:0] awAddr_reg;
  logic [31:0] wData_reg, rdata_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bresp_reg, rresp_reg, irqStat_reg, irqMask_reg;
  logic [11:0] addr_reg;
  logic [7:0] writeData_reg, readData_reg;
  logic wide_reg, opRead_reg, okFlag_reg, failFlag_reg, upper_reg;
  logic [2:0] attempt_reg;
  logic writeFire, idle, boundErr, startRead, startProgram, doneEvent, failEvent;

  assign awready = !awHeld_reg && !bvalid_reg;
  assign wready = !wHeld_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign writeFire = awHeld_reg && wHeld_reg;
  assign idle = (state_reg == SQ_IDLE);
  assign boundErr = rangeError(addr_reg, sizeSync);
  assign startRead = writeFire && idle && awAddr_reg == REG_CTRL && wStrb_reg[0]
                     && wData_reg[CTRL_READ] && !wData_reg[CTRL_PROGRAM];
  assign startProgram = writeFire && idle && awAddr_reg == REG_CTRL && wStrb_reg[0]
                        && wData_reg[CTRL_PROGRAM];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 5'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (writeFire) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (awAddr_reg > REG_IRQ_MASK || awAddr_reg[1:0] != 2'h0) ?
                     RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Setup registers except the interrupt mask are frozen while an operation runs so the pins stay stable.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      addr_reg <= 12'h000;
      writeData_reg <= 8'hFF;
      wide_reg <= 1'b0;
      irqMask_reg <= IRQ_RESET;
    end else if (writeFire) begin
      if (idle && awAddr_reg == REG_ADDR && wStrb_reg[0]) addr_reg[7:0] <= wData_reg[7:0];
      if (idle && awAddr_reg == REG_ADDR && wStrb_reg[1]) addr_reg[11:8] <= wData_reg[11:8];
      if (idle && awAddr_reg == REG_WDATA && wStrb_reg[0]) writeData_reg <= wData_reg[7:0];
      if (idle && awAddr_reg == REG_CTRL && wStrb_reg[0]) wide_reg <= wData_reg[CTRL_WIDE];
      if (awAddr_reg == REG_IRQ_MASK && wStrb_reg[0]) irqMask_reg <= wData_reg[1:0];
    end
  end

  // Hardware set wins over a same-cycle write-one clear.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irqStat_reg <= IRQ_RESET;
    end else begin
      irqStat_reg <= (irqStat_reg & ~((writeFire && awAddr_reg == REG_IRQ_STAT
                      && wStrb_reg[0]) ? wData_reg[1:0] : 2'h0)) | {failEvent, doneEvent};
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= RDATA_RESET;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (araddr)
        REG_CTRL: rdata_reg <= {29'h0, wide_reg, 2'h0};
        REG_ADDR: rdata_reg <= {20'h0, addr_reg};
        REG_WDATA: rdata_reg <= {24'h0, writeData_reg};
        REG_RDATA: rdata_reg <= {24'h0, readData_reg};
        REG_STATUS: rdata_reg <= {21'h0, attempt_reg, 3'h0, supplyMissing, boundErr,
                                  failFlag_reg, okFlag_reg, !idle};
        REG_IRQ_STAT: rdata_reg <= {30'h0, irqStat_reg};
        REG_IRQ_MASK: rdata_reg <= {30'h0, irqMask_reg};
        default: begin
          rdata_reg <= RDATA_RESET;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  logic [1:0] bitIndex_reg;
  logic [7:0] matchCount_reg;
  logic [23:0] cycleTimer_reg;
  logic [15:0] stepTimer_reg;
  logic [3:0] nibbleTarget, nibbleRead, clearMask;
  logic nibbleMatch, bitNeedsPulse, finishMatch, cycleOver, lastAttempt;

  assign nibbleTarget = pickNibble(writeData_reg, upper_reg);
  assign nibbleRead = pickNibble(dataSync, upper_reg);
  assign clearMask = ~nibbleTarget;
  assign nibbleMatch = (nibbleRead == nibbleTarget);
  assign finishMatch = nibbleMatch && matchCount_reg == 8'(MATCH_TARGET - 1);
  // Once the nibble matches, bits to clear keep getting pulsed to finish oxidation.
  assign bitNeedsPulse = clearMask[bitIndex_reg] && (nibbleRead[bitIndex_reg] || nibbleMatch);
  assign cycleOver = cycleTimer_reg >= 24'(CYCLE_LIMIT - 1);
  assign lastAttempt = attempt_reg == 3'(ATTEMPT_LIMIT - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SQ_IDLE: if (startRead || startProgram) state_next = SQ_CHECK;
      SQ_CHECK: state_next = (boundErr || (!opRead_reg && supplyMissing)) ? SQ_IDLE : SQ_SELECT;
      SQ_SELECT: if (stepTimer_reg == 16'(SETTLE_CYCLES - 1))
        state_next = opRead_reg ? SQ_RLATCH : SQ_EVAL;
      SQ_RLATCH: state_next = SQ_IDLE;
      SQ_EVAL: begin
        if (finishMatch) state_next = SQ_OVP;
        else if (cycleOver) state_next = lastAttempt ? SQ_IDLE : SQ_SELECT;
        else if (bitNeedsPulse) state_next = SQ_PULSE;
        else state_next = SQ_SELECT;
      end
      SQ_PULSE: if (stepTimer_reg == 16'(PULSE_CYCLES - 1)) state_next = SQ_GAP;
      SQ_GAP: if (stepTimer_reg == 16'(GAP_CYCLES - 1)) state_next = SQ_SELECT;
      SQ_OVP: if (stepTimer_reg == 16'(OVP_LIMIT - 1))
        state_next = (wide_reg && !upper_reg) ? SQ_SELECT : SQ_IDLE;
      default: state_next = SQ_IDLE;
    endcase
  end

  assign doneEvent = (state_reg == SQ_RLATCH) || (state_reg == SQ_OVP && state_next == SQ_IDLE);
  assign failEvent = state_next == SQ_IDLE && (state_reg == SQ_CHECK || state_reg == SQ_EVAL);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= SQ_IDLE;
      stepTimer_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      stepTimer_reg <= (state_next != state_reg) ? 16'h0000 : stepTimer_reg + 16'h0001;
    end
  end

  // The 400 ms window keeps running through read-back, pulse and gap.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      opRead_reg <= 1'b0;
      upper_reg <= 1'b0;
      bitIndex_reg <= 2'h0;
      matchCount_reg <= 8'h00;
      attempt_reg <= 3'h0;
      cycleTimer_reg <= 24'h000000;
    end else if (state_reg == SQ_IDLE) begin
      if (startRead || startProgram) begin
        opRead_reg <= startRead;
        upper_reg <= 1'b0;
        bitIndex_reg <= 2'h0;
        matchCount_reg <= 8'h00;
        attempt_reg <= 3'h0;
        cycleTimer_reg <= 24'h000000;
      end
    end else if (state_reg == SQ_OVP) begin
      if (state_next == SQ_SELECT) begin
        upper_reg <= 1'b1;
        bitIndex_reg <= 2'h0;
        matchCount_reg <= 8'h00;
        attempt_reg <= 3'h0;
        cycleTimer_reg <= 24'h000000;
      end
    end else if (!opRead_reg && state_reg != SQ_CHECK) begin
      cycleTimer_reg <= cycleTimer_reg + 24'h000001;
      if (state_reg == SQ_EVAL) begin
        bitIndex_reg <= bitIndex_reg + 2'h1;
        if (nibbleMatch) matchCount_reg <= matchCount_reg + 8'h01;
        if (cycleOver && !finishMatch) begin
          attempt_reg <= attempt_reg + 3'h1;
          matchCount_reg <= 8'h00;
          cycleTimer_reg <= 24'h000000;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      okFlag_reg <= 1'b0;
      failFlag_reg <= 1'b0;
      readData_reg <= 8'h00;
    end else begin
      if (startRead || startProgram) begin
        okFlag_reg <= 1'b0;
        failFlag_reg <= 1'b0;
      end
      if (doneEvent) okFlag_reg <= 1'b1;
      if (failEvent) failFlag_reg <= 1'b1;
      if (state_reg == SQ_RLATCH) readData_reg <= dataSync;
    end
  end

  // ----------------------------------------------------------------------
  // PROM pins
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      promAddr <= 11'h000;
      promSelectN <= 1'b1;
      supplyPulse <= 1'b0;
      currentDrive <= 8'h00;
    end else begin
      promAddr <= addr_reg[10:0];
      promSelectN <= !(state_next == SQ_SELECT || state_next == SQ_EVAL
                       || state_next == SQ_RLATCH);
      supplyPulse <= state_next == SQ_PULSE || state_next == SQ_OVP;
      if (state_next == SQ_PULSE && state_reg == SQ_EVAL)
        currentDrive <= driveVector(upper_reg, 4'h1 << bitIndex_reg);
      else if (state_next == SQ_OVP)
        currentDrive <= driveVector(upper_reg, clearMask);
      else if (state_next != SQ_PULSE)
        currentDrive <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence sPulseDecision;
    state_reg == SQ_EVAL && bitNeedsPulse && !finishMatch && !cycleOver;
  endsequence
  sequence sOvpStart;
    state_reg == SQ_OVP && $past(state_reg) == SQ_EVAL && clearMask != 4'h0;
  endsequence

  a_bit_stepping:
    assert property (state_reg == SQ_EVAL |=> bitIndex_reg == $past(bitIndex_reg) + 2'h1)
    else $error("bit select did not advance after read-back");
  a_readback_first:
    assert property ($rose(supplyPulse) |-> $past(state_reg) == SQ_EVAL)
    else $error("pulse started without a read-back");
  a_single_bit_pulse:
    assert property (sPulseDecision |=> supplyPulse && $onehot(currentDrive) && promSelectN)
    else $error("pulse did not drive exactly one bit");
  a_match_overprog:
    assert property (state_reg == SQ_EVAL && finishMatch |=> state_reg == SQ_OVP)
    else $error("128th match did not start over-programming");
  a_ovp_drive:
    assert property (sOvpStart |-> (supplyPulse && currentDrive != 8'h00)[*8])
    else $error("over-programming drive dropped early");
  a_lower_first:
    assert property ($rose(upper_reg) |-> $past(state_reg) == SQ_OVP && wide_reg)
    else $error("upper nibble began before lower finished");
  a_retry_limit:
    assert property (state_reg == SQ_EVAL && cycleOver && lastAttempt && !finishMatch
                     |=> state_reg == SQ_IDLE && failFlag_reg && attempt_reg == 3'h4)
    else $error("fourth failed window did not abort");
  a_range_abort:
    assert property (state_reg == SQ_CHECK && boundErr |=> state_reg == SQ_IDLE ##1 irqStat_reg[1])
    else $error("out-of-range address was not aborted");
  a_top_bit:
    assert property (addr_reg[11] || (sizeSync == 2'h0 && addr_reg[10:8] != 3'h0) |-> boundErr)
    else $error("boundary error missing");
  a_read_quiet:
    assert property (opRead_reg && !idle |-> !supplyPulse && currentDrive == 8'h00)
    else $error("read applied a programming pulse");
  a_read_data:
    assert property (state_reg == SQ_RLATCH |=> readData_reg == $past(dataSync) && okFlag_reg)
    else $error("read data not returned");

endmodule

// >>> src/bpps_pkg.sv
// Shared constants, register map and state type of the PROM program sequencer.
package bpps_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_MHZ = 25;
  localparam int CYCLE_MS = 400;
  localparam int CYCLE_CYCLES = CYCLE_MS * 1000 * CLOCK_MHZ;
  localparam int OVP_US = 2500;
  localparam int OVP_CYCLES = OVP_US * CLOCK_MHZ;
  localparam int PULSE_NS = 8000;
  localparam int PULSE_CYCLES = (PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int GAP_NS = 1800;
  localparam int GAP_CYCLES = (GAP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SETTLE_CYCLES = 6;
  localparam int MATCH_TARGET = 128;
  localparam int ATTEMPT_LIMIT = 4;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int AXI_ADDR_W = 5;
  localparam int PROM_ADDR_W = 12;
  localparam int PROM_DATA_W = 8;
  localparam int SYNC_W = 11;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_IRQ_STAT = 5'h14;
  localparam logic [4:0] REG_IRQ_MASK = 5'h18;
  localparam int CTRL_READ = 0;
  localparam int CTRL_PROGRAM = 1;
  localparam int CTRL_WIDE = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_OK = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_BOUND = 3;
  localparam int ST_SUPPLY = 4;
  localparam int ST_ATTEMPT = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERROR = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  typedef enum {
    SQ_IDLE, SQ_CHECK, SQ_SELECT, SQ_RLATCH, SQ_EVAL, SQ_PULSE, SQ_GAP, SQ_OVP
  } bpps_state_t;

endpackage

// >>> src/bpps_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module bpps_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit moves only once the second and third stages agree.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (!resetn) begin
          level_reg[i] <= 1'b0;
        end else if (stage2_reg[i] == stage3_reg[i]) begin
          level_reg[i] <= stage2_reg[i];
        end
      end
    end
  endgenerate

  assign level = level_reg;

endmodule

// >>> test/bpps_prom_model.sv
// Behavioural fuse PROM that sits on the socket side of the sequencer.
`timescale 1ns/1ps
module bpps_prom_model #(
  parameter logic [10:0] STUCK_ADDR = 11'h070
) (
  input wire logic clock,
  input wire logic [10:0] promAddr,
  input wire logic promSelectN,
  input wire logic supplyPulse,
  input wire logic [7:0] currentDrive,
  input wire logic slowBlow,
  output logic [7:0] promData
);
  logic [7:0] mem [0:2047];
  logic [7:0] lastOut;
  logic [7:0] pulseDrive;
  logic [1:0] hits [0:7];
  logic prevPulse;

  // Upper half holds a known pattern so reads can be told apart from blank cells.
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = (i >= 1024) ? (i[7:0] ^ 8'hA5) : 8'hFF;
    end
    for (int b = 0; b < 8; b++) begin
      hits[b] = 2'h0;
    end
    lastOut = 8'h00;
    pulseDrive = 8'h00;
    prevPulse = 1'b0;
  end

  // A deselected part floats, so show the inverse of the last word, never a stale copy.
  assign promData = promSelectN ? ~lastOut : mem[promAddr];

  // A fuse opens at the end of a pulse; a slow part needs three pulses, one cell never opens.
  always @(posedge clock) begin
    prevPulse <= supplyPulse;
    if (!promSelectN) begin
      lastOut <= mem[promAddr];
    end
    if (supplyPulse) begin
      pulseDrive <= currentDrive;
    end
    if (prevPulse && !supplyPulse && promAddr != STUCK_ADDR) begin
      for (int b = 0; b < 8; b++) begin
        if (pulseDrive[b]) begin
          hits[b] <= hits[b] + 2'h1;
          if (!slowBlow || hits[b] == 2'h2) begin
            mem[promAddr][b] <= 1'b0;
            hits[b] <= 2'h0;
          end
        end
      end
    end
  end
endmodule

// >>> test/bipolar_prom_program_sequencer_bench.sv
// Register-level bench for the PROM program sequencer.
`timescale 1ns/1ps
module bipolar_prom_program_sequencer_bench;
  import bpps_pkg::*;
  // One window must hold 128 matches of a one-zero nibble, and over-programming outlasts a pulse.
  localparam int CYCL = 10000;
  localparam int OVPL = 250;
  logic clock, resetn, awvalid, wvalid, bready, arvalid, rready, hvMissing, slowBlow;
  logic awready, wready, bvalid, arready, rvalid, promSelectN, supplyPulse, irq;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, sizeSelectSwitch;
  logic [10:0] promAddr;
  logic [7:0] promData, currentDrive, ovpDrive;
  logic sawUpper, sawPulse, readSeen, inPulse;
  int miscompares, nTests, cycles, maxRun, run, monErr;

  bpps_sequencer #(.CYCLE_LIMIT(CYCL), .OVP_LIMIT(OVPL)) uut (.clock(clock), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .promAddr(promAddr), .promSelectN(promSelectN),
    .promData(promData), .supplyPulse(supplyPulse), .currentDrive(currentDrive),
    .hvMissing(hvMissing), .sizeSelectSwitch(sizeSelectSwitch), .irq(irq));
  bpps_prom_model prom (.clock(clock), .promAddr(promAddr), .promSelectN(promSelectN),
    .supplyPulse(supplyPulse), .currentDrive(currentDrive), .slowBlow(slowBlow),
    .promData(promData));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) check("write answer", 1, 0);
  endtask

  task automatic rdReg(input logic [4:0] a);
    bit done;
    done = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) check("read answer", 1, 0);
  endtask

  // Software polls busy, as the control board would; the bound keeps a hang finite.
  task automatic waitDone();
    rdReg(REG_STATUS);
    for (int i = 0; i < 30000 && rd[ST_BUSY]; i++) rdReg(REG_STATUS);
  endtask

  // Pin monitor: drive only under supply pulses, read-back before each pulse, nibble order.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      giveVerdict();
    end
    // A supply run longer than one pulse can only be the over-programming phase.
    if (supplyPulse === 1'b1) begin
      run++;
      if (run > PULSE_CYCLES) ovpDrive = currentDrive;
      if (run > maxRun) maxRun = run;
    end else begin
      run = 0;
    end
    if (resetn && currentDrive !== 8'h00 && supplyPulse !== 1'b1) monErr++;
    if (supplyPulse && !readSeen) monErr++;
    if (supplyPulse) begin
      inPulse = 1;
      sawPulse = 1;
    end else if (inPulse) begin
      inPulse = 0;
      readSeen = 0;
    end
    if (!promSelectN) readSeen = 1;
    if (currentDrive[7:4] != 4'h0) sawUpper = 1;
    if (sawUpper && currentDrive[3:0] != 4'h0) monErr++;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hvMissing, slowBlow} = 7'h00;
    {sawUpper, sawPulse, readSeen, inPulse} = 4'h0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    sizeSelectSwitch = 2'h3;
    resetn = 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rdReg(REG_WDATA);
    check("WDATA reset", 32'h000000FF, rd);
    rdReg(REG_IRQ_MASK);
    check("IRQ_MASK reset", 32'h00000000, rd);
    rdReg(5'h1C);
    check("unmapped read", 32'h00000000, rd);
    check("unmapped rresp", RESP_SLVERR, resp);
    wr(5'h1C, 32'h00000001);
    check("unmapped bresp", RESP_SLVERR, resp);
    $display("test reset done");

    wr(REG_ADDR, 32'h000004C3);
    wr(REG_CTRL, 32'h00000001);
    waitDone();
    check("read status", 32'h1, rd[2:1]);
    rdReg(REG_RDATA);
    check("read word", 32'h00000066, rd);
    check("read pulses", 32'h0, sawPulse);
    check("irq masked", 32'h0, irq);
    wr(REG_IRQ_MASK, 32'h00000001);
    check("irq raised", 32'h1, irq);
    wr(REG_IRQ_STAT, 32'h00000001);
    check("irq cleared", 32'h0, irq);
    $display("test read done");

    for (int s = 0; s < 4; s++) begin
      sizeSelectSwitch <= s[1:0];
      wr(REG_ADDR, (32'd256 << s) - 32'd1);
      repeat (8) @(posedge clock);
      rdReg(REG_STATUS);
      check("bound at top", 32'h0, rd[ST_BOUND]);
      wr(REG_ADDR, 32'd256 << s);
      rdReg(REG_STATUS);
      check("bound past top", 32'h1, rd[ST_BOUND]);
      wr(REG_CTRL, 32'h00000001);
      waitDone();
      check("bound abort", 32'h6, rd[3:1]);
    end
    wr(REG_ADDR, 32'h00000801);
    rdReg(REG_STATUS);
    check("top bit bound", 32'h1, rd[ST_BOUND]);
    $display("test bounds done");

    hvMissing <= 1'b1;
    wr(REG_ADDR, 32'h00000033);
    wr(REG_WDATA, 32'h0000005E);
    repeat (8) @(posedge clock);
    rdReg(REG_STATUS);
    check("supply flag", 32'h1, rd[ST_SUPPLY]);
    wr(REG_CTRL, 32'h00000002);
    waitDone();
    check("supply abort", 32'h2, rd[2:1]);
    hvMissing <= 1'b0;
    repeat (8) @(posedge clock);
    $display("test supply done");

    maxRun = 0;
    wr(REG_CTRL, 32'h00000002);
    waitDone();
    check("program status", 32'h1, rd[2:1]);
    check("overprogram drive", 32'h01, ovpDrive);
    check("overprogram length", 32'h1, maxRun >= OVPL);
    wr(REG_CTRL, 32'h00000001);
    waitDone();
    rdReg(REG_RDATA);
    check("narrow word", 32'h000000FE, rd);
    $display("test narrow done");

    slowBlow <= 1'b1;
    sawUpper = 0;
    wr(REG_ADDR, 32'h00000044);
    wr(REG_WDATA, 32'h0000007E);
    wr(REG_CTRL, 32'h00000006);
    waitDone();
    check("wide status", 32'h1, rd[2:1]);
    check("upper overprogram", 32'h80, ovpDrive);
    wr(REG_CTRL, 32'h00000001);
    waitDone();
    rdReg(REG_RDATA);
    check("wide word", 32'h0000007E, rd);
    slowBlow <= 1'b0;
    $display("test wide done");

    sawUpper = 0;
    wr(REG_ADDR, 32'h00000070);
    wr(REG_WDATA, 32'h00000000);
    wr(REG_IRQ_MASK, 32'h00000003);
    wr(REG_IRQ_STAT, 32'h00000003);
    wr(REG_CTRL, 32'h00000002);
    waitDone();
    check("retry fail", 32'h2, rd[2:1]);
    check("attempts", 32'h4, rd[10:8]);
    check("error irq", 32'h1, irq);
    wr(REG_IRQ_STAT, 32'h00000003);
    check("error cleared", 32'h0, irq);
    $display("test retry done");
    check("pin monitor", 32'h0, monErr);
    giveVerdict();
  end
endmodule
